//--- rtl/tpm_pkg.sv
// Package with object indices, field positions and reset values of the probe and motion objects.
package tpm_pkg;
   // Object dictionary indices.
   localparam logic [15:0] IDX_QUICK_STOP_DEC = 16'h6085;
   localparam logic [15:0] IDX_HOMING_METHOD = 16'h6098;
   localparam logic [15:0] IDX_HOMING_SPEED = 16'h6099;
   localparam logic [15:0] IDX_HOMING_ACCEL = 16'h609A;
   localparam logic [15:0] IDX_PROBE_FUNC = 16'h60B8;
   localparam logic [15:0] IDX_PROBE_STATUS = 16'h60B9;
   localparam logic [15:0] IDX_P1_RISE = 16'h60BA;
   localparam logic [15:0] IDX_P1_FALL = 16'h60BB;
   localparam logic [15:0] IDX_P2_RISE = 16'h60BC;
   localparam logic [15:0] IDX_P2_FALL = 16'h60BD;
   localparam logic [15:0] IDX_INPUT_MON = 16'h60FD;
   localparam logic [15:0] IDX_TARGET_SPEED = 16'h60FF;
   localparam logic [15:0] IDX_SUPPORTED_MODES = 16'h6502;
   // Subindices of the homing speed record.
   localparam logic [7:0] SUB_SPEED_FAST = 8'h01;
   localparam logic [7:0] SUB_SPEED_SLOW = 8'h02;
   // Reset values.
   localparam logic [31:0] RST_QUICK_STOP_DEC = 32'h0007A120;
   localparam logic [7:0] RST_HOMING_METHOD = 8'h11;
   localparam logic [7:0] HOMING_METHOD_MAX = 8'h23;
   localparam logic [31:0] RST_SPEED_FAST = 32'h00002710;
   localparam logic [31:0] RST_SPEED_SLOW = 32'h000007D0;
   localparam logic [31:0] RST_HOMING_ACCEL = 32'h000186A0;
   localparam logic [15:0] RST_PROBE_FUNC = 16'h0000;
   localparam logic [31:0] RST_CAPTURE = 32'h00000000;
   localparam logic [31:0] RST_TARGET_SPEED = 32'h00000000;
   localparam logic [31:0] SUPPORTED_MODES = 32'h000000A5;
   // Probe function word fields, probe n uses base 0 or 8.
   localparam int PF_ENABLE = 0;
   localparam int PF_RISE_EN = 4;
   localparam int PF_FALL_EN = 5;
   localparam int PROBE_STRIDE = 8;
   localparam logic [15:0] PF_WRITABLE = 16'h3131;
   // Probe status word fields.
   localparam int PS_ENABLE = 0;
   localparam int PS_RISE_DONE = 1;
   localparam int PS_FALL_DONE = 2;
   // Input monitor word fields.
   localparam int IM_CCW_LIMIT = 0;
   localparam int IM_CW_LIMIT = 1;
   localparam int IM_HOME = 2;
   localparam int IM_ISO_BASE = 16;
   localparam int ISO_COUNT = 6;
   // Supported mode bits.
   localparam int MODE_PROFILE_POSITION = 0;
   localparam int MODE_PROFILE_VELOCITY = 2;
   localparam int MODE_HOMING = 5;
   localparam int MODE_CYCLIC_SYNC_POSITION = 7;
endpackage

//--- rtl/tpm_probe_unit.sv
// One touch probe: edge detection and rising and falling position capture.
`timescale 1ns/100ps
module tpm_probe_unit
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic probeIn,
   input wire logic probeEnable,
   input wire logic riseEnable,
   input wire logic fallEnable,
   input wire logic [31:0] actualPosition,
   output logic riseDone,
   output logic fallDone,
   output logic [31:0] riseCapture,
   output logic [31:0] fallCapture
);
   logic probePrev_r, probePrev_nxt;
   logic riseDone_r, riseDone_nxt, fallDone_r, fallDone_nxt;
   logic [31:0] riseCap_r, riseCap_nxt, fallCap_r, fallCap_nxt;
   logic riseEdge, fallEdge;

   always_comb
   begin
      riseEdge = probeIn & ~probePrev_r;
      fallEdge = ~probeIn & probePrev_r;
      probePrev_nxt = probeIn;
      riseCap_nxt = riseCap_r;
      fallCap_nxt = fallCap_r;
      riseDone_nxt = riseDone_r;
      fallDone_nxt = fallDone_r;
      // A disabled edge drops its flag so the next capture is armed.
      if (!(probeEnable && riseEnable))
      begin
         riseDone_nxt = 1'b0;
      end
      else if (riseEdge)
      begin
         riseCap_nxt = actualPosition;
         riseDone_nxt = 1'b1;
      end
      if (!(probeEnable && fallEnable))
      begin
         fallDone_nxt = 1'b0;
      end
      else if (fallEdge)
      begin
         fallCap_nxt = actualPosition;
         fallDone_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         probePrev_r <= 1'b0;
         riseDone_r <= 1'b0;
         fallDone_r <= 1'b0;
         riseCap_r <= tpm_pkg::RST_CAPTURE;
         fallCap_r <= tpm_pkg::RST_CAPTURE;
      end
      else if (clkEn)
      begin
         probePrev_r <= probePrev_nxt;
         riseDone_r <= riseDone_nxt;
         fallDone_r <= fallDone_nxt;
         riseCap_r <= riseCap_nxt;
         fallCap_r <= fallCap_nxt;
      end
   end

   assign riseDone = riseDone_r;
   assign fallDone = fallDone_r;
   assign riseCapture = riseCap_r;
   assign fallCapture = fallCap_r;
endmodule

//--- rtl/tpm_touch_probe_motion.sv
// Top of the touch probe and motion parameter object set.
//
// Summary of operation
// - On a limit or home hit in position, velocity or homing mode the quick-stop deceleration (default 500000) is issued.
// - The homing method is a signed 8-bit read-write value accepting 17 to 35 and resetting to 17.
// - Two unsigned 32-bit homing speeds are held, fast defaulting to 10000 and slow to 2000.
// - One homing acceleration, default 100000, sets both acceleration and deceleration while homing.
// - Probe function bits 0, 4 and 5 enable probe one, its rising latch and its falling latch.
// - Probe function bits 8, 12 and 13 do the same for probe two; other bits are reserved.
// - Each probe captures position into its rising latch on a rising edge and its falling latch on a falling edge.
// - Probe status bits 0, 1, 2 show probe one enabled, rising captured and falling captured; bits 3 to 7 read zero.
// - Probe status bits 8, 9, 10 show the same for probe two; bits 11 to 15 read zero.
// - Probe one has read-only rising and falling capture values that reset to zero.
// - Probe two has read-only rising and falling capture values that reset to zero.
// - The input monitor shows counterclockwise limit, clockwise limit and home in bits 0 to 2, active high.
// - Input monitor bits 16 to 21 show the six isolated inputs; other bits read zero.
// - The target speed is a signed 32-bit value whose sign picks direction and which resets to zero.
// - The supported-modes word is a read-only mask with bits 0, 2, 5 and 7 for the four modes.
// - The supported-modes word reads 0x000000A5.
`timescale 1ns/100ps
module tpm_touch_probe_motion
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic odWrite,
   input wire logic odRead,
   input wire logic [15:0] odIndex,
   input wire logic [7:0] odSubIndex,
   input wire logic [31:0] odWriteData,
   input wire logic [31:0] actualPosition,
   input wire logic ccwLimitIn,
   input wire logic cwLimitIn,
   input wire logic homeSensorIn,
   input wire logic [5:0] isolatedInputs,
   input wire logic probeOneIn,
   input wire logic probeTwoIn,
   input wire logic profilePositionMode,
   input wire logic profileVelocityMode,
   input wire logic homingMode,
   output logic [31:0] odReadData,
   output logic odAck,
   output logic odError,
   output logic [31:0] quickStopDecel,
   output logic quickStopRequest,
   output logic [7:0] homingMethod,
   output logic [31:0] homingSpeedFast,
   output logic [31:0] homingSpeedSlow,
   output logic [31:0] homingAccel,
   output logic [31:0] homingDecel,
   output logic [31:0] targetSpeed,
   output logic reverseDirection
);
   logic [31:0] qsDec_r, qsDec_nxt, spFast_r, spFast_nxt, spSlow_r, spSlow_nxt;
   logic [31:0] hAcc_r, hAcc_nxt, tSpeed_r, tSpeed_nxt;
   logic [7:0] hMethod_r, hMethod_nxt;
   logic [15:0] pFunc_r, pFunc_nxt;
   logic [31:0] rdData_r, rdData_nxt;
   logic ack_r, ack_nxt, err_r, err_nxt, qsReq_r, qsReq_nxt;
   logic [31:0] inMon_r, inMon_nxt;
   logic p1Rise, p1Fall, p2Rise, p2Fall;
   logic [31:0] p1RiseCap, p1FallCap, p2RiseCap, p2FallCap;
   logic [15:0] probeStatus;
   logic hit, known, writable;

   function automatic logic [2:0] probe_fields(input logic [15:0] func, input int base);
      probe_fields = {func[base + tpm_pkg::PF_FALL_EN], func[base + tpm_pkg::PF_RISE_EN],
                      func[base + tpm_pkg::PF_ENABLE]};
   endfunction

   tpm_probe_unit probeOne
   (
      .core_clk(core_clk),
      .reset(reset),
      .clkEn(clkEn),
      .probeIn(probeOneIn),
      .probeEnable(pFunc_r[tpm_pkg::PF_ENABLE]),
      .riseEnable(pFunc_r[tpm_pkg::PF_RISE_EN]),
      .fallEnable(pFunc_r[tpm_pkg::PF_FALL_EN]),
      .actualPosition(actualPosition),
      .riseDone(p1Rise),
      .fallDone(p1Fall),
      .riseCapture(p1RiseCap),
      .fallCapture(p1FallCap)
   );

   tpm_probe_unit probeTwo
   (
      .core_clk(core_clk),
      .reset(reset),
      .clkEn(clkEn),
      .probeIn(probeTwoIn),
      .probeEnable(pFunc_r[tpm_pkg::PROBE_STRIDE + tpm_pkg::PF_ENABLE]),
      .riseEnable(pFunc_r[tpm_pkg::PROBE_STRIDE + tpm_pkg::PF_RISE_EN]),
      .fallEnable(pFunc_r[tpm_pkg::PROBE_STRIDE + tpm_pkg::PF_FALL_EN]),
      .actualPosition(actualPosition),
      .riseDone(p2Rise),
      .fallDone(p2Fall),
      .riseCapture(p2RiseCap),
      .fallCapture(p2FallCap)
   );

   // Object access: decode and update of writable objects.
   always_comb
   begin
      probeStatus = 16'h0000;
      probeStatus[tpm_pkg::PS_ENABLE] = pFunc_r[tpm_pkg::PF_ENABLE];
      probeStatus[tpm_pkg::PS_RISE_DONE] = p1Rise;
      probeStatus[tpm_pkg::PS_FALL_DONE] = p1Fall;
      probeStatus[tpm_pkg::PROBE_STRIDE + tpm_pkg::PS_ENABLE] =
         pFunc_r[tpm_pkg::PROBE_STRIDE + tpm_pkg::PF_ENABLE];
      probeStatus[tpm_pkg::PROBE_STRIDE + tpm_pkg::PS_RISE_DONE] = p2Rise;
      probeStatus[tpm_pkg::PROBE_STRIDE + tpm_pkg::PS_FALL_DONE] = p2Fall;
      qsDec_nxt = qsDec_r;
      hMethod_nxt = hMethod_r;
      spFast_nxt = spFast_r;
      spSlow_nxt = spSlow_r;
      hAcc_nxt = hAcc_r;
      pFunc_nxt = pFunc_r;
      tSpeed_nxt = tSpeed_r;
      rdData_nxt = rdData_r;
      hit = odRead | odWrite;
      known = 1'b1;
      writable = 1'b0;
      rdData_nxt = 32'h00000000;
      unique case (odIndex)
         tpm_pkg::IDX_QUICK_STOP_DEC:
         begin
            rdData_nxt = qsDec_r;
            writable = 1'b1;
            if (odWrite)
            begin
               qsDec_nxt = odWriteData;
            end
         end
         tpm_pkg::IDX_HOMING_METHOD:
         begin
            rdData_nxt = {{24{hMethod_r[7]}}, hMethod_r};
            // Values outside the method range are refused so the sequence never sees them.
            writable = ($signed(odWriteData[7:0]) >= $signed(tpm_pkg::RST_HOMING_METHOD)) &&
                       ($signed(odWriteData[7:0]) <= $signed(tpm_pkg::HOMING_METHOD_MAX));
            if (odWrite && writable)
            begin
               hMethod_nxt = odWriteData[7:0];
            end
            if (odRead)
            begin
               writable = 1'b1;
            end
         end
         tpm_pkg::IDX_HOMING_SPEED:
         begin
            writable = 1'b1;
            if (odSubIndex == tpm_pkg::SUB_SPEED_FAST)
            begin
               rdData_nxt = spFast_r;
               if (odWrite)
               begin
                  spFast_nxt = odWriteData;
               end
            end
            else if (odSubIndex == tpm_pkg::SUB_SPEED_SLOW)
            begin
               rdData_nxt = spSlow_r;
               if (odWrite)
               begin
                  spSlow_nxt = odWriteData;
               end
            end
            else
            begin
               known = 1'b0;
            end
         end
         tpm_pkg::IDX_HOMING_ACCEL:
         begin
            rdData_nxt = hAcc_r;
            writable = 1'b1;
            if (odWrite)
            begin
               hAcc_nxt = odWriteData;
            end
         end
         tpm_pkg::IDX_PROBE_FUNC:
         begin
            rdData_nxt = {16'h0000, pFunc_r};
            writable = 1'b1;
            if (odWrite)
            begin
               pFunc_nxt = odWriteData[15:0] & tpm_pkg::PF_WRITABLE;
            end
         end
         tpm_pkg::IDX_PROBE_STATUS:
         begin
            rdData_nxt = {16'h0000, probeStatus};
         end
         tpm_pkg::IDX_P1_RISE:
         begin
            rdData_nxt = p1RiseCap;
         end
         tpm_pkg::IDX_P1_FALL:
         begin
            rdData_nxt = p1FallCap;
         end
         tpm_pkg::IDX_P2_RISE:
         begin
            rdData_nxt = p2RiseCap;
         end
         tpm_pkg::IDX_P2_FALL:
         begin
            rdData_nxt = p2FallCap;
         end
         tpm_pkg::IDX_INPUT_MON:
         begin
            rdData_nxt = inMon_r;
         end
         tpm_pkg::IDX_TARGET_SPEED:
         begin
            rdData_nxt = tSpeed_r;
            writable = 1'b1;
            if (odWrite)
            begin
               tSpeed_nxt = odWriteData;
            end
         end
         tpm_pkg::IDX_SUPPORTED_MODES:
         begin
            rdData_nxt = tpm_pkg::SUPPORTED_MODES;
         end
         default:
         begin
            known = 1'b0;
         end
      endcase
      if (!odRead)
      begin
         rdData_nxt = rdData_r;
      end
      ack_nxt = hit;
      err_nxt = hit & (~known | (odWrite & ~writable));
   end

   // Input monitor and quick-stop request; inputs are taken as synchronous.
   always_comb
   begin
      inMon_nxt = 32'h00000000;
      inMon_nxt[tpm_pkg::IM_CCW_LIMIT] = ccwLimitIn;
      inMon_nxt[tpm_pkg::IM_CW_LIMIT] = cwLimitIn;
      inMon_nxt[tpm_pkg::IM_HOME] = homeSensorIn;
      inMon_nxt[tpm_pkg::IM_ISO_BASE +: tpm_pkg::ISO_COUNT] = isolatedInputs;
      qsReq_nxt = (ccwLimitIn | cwLimitIn | homeSensorIn) &
                  (profilePositionMode | profileVelocityMode | homingMode);
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         qsDec_r <= tpm_pkg::RST_QUICK_STOP_DEC;
         hMethod_r <= tpm_pkg::RST_HOMING_METHOD;
         spFast_r <= tpm_pkg::RST_SPEED_FAST;
         spSlow_r <= tpm_pkg::RST_SPEED_SLOW;
         hAcc_r <= tpm_pkg::RST_HOMING_ACCEL;
         pFunc_r <= tpm_pkg::RST_PROBE_FUNC;
         tSpeed_r <= tpm_pkg::RST_TARGET_SPEED;
         rdData_r <= 32'h00000000;
         ack_r <= 1'b0;
         err_r <= 1'b0;
         qsReq_r <= 1'b0;
         inMon_r <= 32'h00000000;
      end
      else if (clkEn)
      begin
         qsDec_r <= qsDec_nxt;
         hMethod_r <= hMethod_nxt;
         spFast_r <= spFast_nxt;
         spSlow_r <= spSlow_nxt;
         hAcc_r <= hAcc_nxt;
         pFunc_r <= pFunc_nxt;
         tSpeed_r <= tSpeed_nxt;
         rdData_r <= rdData_nxt;
         ack_r <= ack_nxt;
         err_r <= err_nxt;
         qsReq_r <= qsReq_nxt;
         inMon_r <= inMon_nxt;
      end
   end

   assign odReadData = rdData_r;
   assign odAck = ack_r;
   assign odError = err_r;
   assign quickStopDecel = qsDec_r;
   assign quickStopRequest = qsReq_r;
   assign homingMethod = hMethod_r;
   assign homingSpeedFast = spFast_r;
   assign homingSpeedSlow = spSlow_r;
   // The shared register keeps homing ramps symmetric.
   assign homingAccel = hAcc_r;
   assign homingDecel = hAcc_r;
   assign targetSpeed = tSpeed_r;
   assign reverseDirection = tSpeed_r[31];

   logic [2:0] p1Fields;
   assign p1Fields = probe_fields(pFunc_r, 0);

   AST_STATUS_MIRRORS_ENABLE: assert property (@(posedge core_clk) disable iff (reset)
      probeStatus[tpm_pkg::PS_ENABLE] == p1Fields[0] &&
      probeStatus[7:3] == 5'h00 && probeStatus[15:11] == 5'h00)
      else $error("Probe status enable or reserved bits wrong.");
   AST_RISE_CAPTURE: assert property (@(posedge core_clk) disable iff (reset)
      clkEn && probeOneIn && !$past(probeOneIn) && p1Fields[1:0] == 2'b11 && $past(clkEn)
      |=> p1Rise && p1RiseCap == $past(actualPosition))
      else $error("Rising capture missed.");
   AST_FLAG_CLEARS: assert property (@(posedge core_clk) disable iff (reset)
      clkEn && !p1Fields[0] |=> !p1Rise && !p1Fall)
      else $error("Capture flag not cleared.");
   AST_MODES_CONST: assert property (@(posedge core_clk) disable iff (reset)
      odAck && $past(odRead) && $past(odIndex) == tpm_pkg::IDX_SUPPORTED_MODES
      |-> odReadData == 32'h000000A5)
      else $error("Supported modes wrong.");
   AST_METHOD_RANGE: assert property (@(posedge core_clk) disable iff (reset)
      $signed(hMethod_r) >= 8'sd17 && $signed(hMethod_r) <= 8'sd35)
      else $error("Homing method out of range.");
   AST_HOMING_SYMMETRIC: assert property (@(posedge core_clk) disable iff (reset)
      homingAccel == homingDecel)
      else $error("Homing ramps differ.");
   AST_QUICK_STOP: assert property (@(posedge core_clk) disable iff (reset)
      clkEn && homingMode && homeSensorIn |=> quickStopRequest)
      else $error("Quick stop not requested.");
   AST_INPUT_MON: assert property (@(posedge core_clk) disable iff (reset)
      clkEn |=> inMon_r[21:16] == $past(isolatedInputs) && inMon_r[31:22] == 10'h000)
      else $error("Input monitor wrong.");
endmodule

//--- dv/tpm_od_master.sv
// Fieldbus master model that issues object dictionary reads and writes.
`timescale 1ns/100ps
module tpm_od_master
(
   input wire logic core_clk,
   output logic odWrite,
   output logic odRead,
   output logic [15:0] odIndex,
   output logic [7:0] odSubIndex,
   output logic [31:0] odWriteData,
   input wire logic [31:0] odReadData,
   input wire logic odAck,
   input wire logic odError
);
   initial
   begin
      odWrite = 1'b0;
      odRead = 1'b0;
      odIndex = 16'h0000;
      odSubIndex = 8'h00;
      odWriteData = 32'h00000000;
   end

   // Released index, subindex and data lines show the inverse of the last value so that a stale sample cannot pass.
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      @(negedge core_clk);
      odWrite = wr;
      odRead = ~wr;
      odIndex = idx;
      odSubIndex = sub;
      odWriteData = wd;
      // The answer stands only for the cycle after the taking edge, so it is sampled before release.
      @(negedge core_clk);
      rd = odReadData;
      err = odError;
      // A missing answer turns the error flag unknown, which no expectation matches.
      if (odAck !== 1'b1)
         err = 1'bx;
      odWrite = 1'b0;
      odRead = 1'b0;
      odIndex = ~idx;
      odSubIndex = ~sub;
      odWriteData = ~wd;
   endtask
endmodule

//--- dv/tpm_touch_probe_motion_tb.sv
// Self-checking bench of the touch probe and motion object set.
`timescale 1ns/100ps
module tpm_touch_probe_motion_tb;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic odWrite, odRead, odAck, odError, quickStopRequest, reverseDirection;
   logic [15:0] odIndex;
   logic [7:0] odSubIndex, homingMethod;
   logic [31:0] odWriteData, odReadData, quickStopDecel, homingSpeedFast, homingSpeedSlow;
   logic [31:0] homingAccel, homingDecel, targetSpeed;
   logic [31:0] actualPosition = 32'h00000000;
   logic ccwLimitIn = 1'b0;
   logic cwLimitIn = 1'b0;
   logic homeSensorIn = 1'b0;
   logic [5:0] isolatedInputs = 6'h00;
   logic probeOneIn = 1'b0;
   logic probeTwoIn = 1'b0;
   logic profilePositionMode = 1'b0;
   logic profileVelocityMode = 1'b0;
   logic homingMode = 1'b0;
   logic clkEn = 1'b1;
   int n_errors = 0;
   int cmp_count = 0;

   always #20 core_clk = ~core_clk;

   tpm_touch_probe_motion dut
   (
      .core_clk, .reset, .clkEn, .odWrite, .odRead, .odIndex, .odSubIndex,
      .odWriteData, .actualPosition, .ccwLimitIn, .cwLimitIn, .homeSensorIn,
      .isolatedInputs, .probeOneIn, .probeTwoIn, .profilePositionMode,
      .profileVelocityMode, .homingMode, .odReadData, .odAck, .odError, .quickStopDecel,
      .quickStopRequest, .homingMethod, .homingSpeedFast, .homingSpeedSlow, .homingAccel,
      .homingDecel, .targetSpeed, .reverseDirection
   );

   tpm_od_master m
   (
      .core_clk, .odWrite, .odRead, .odIndex, .odSubIndex, .odWriteData, .odReadData,
      .odAck, .odError
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
      logic [31:0] r;
      logic er;
      m.access(1'b0, i, s, 32'h00000000, r, er);
      chk(r, e);
      chk({31'h0, er}, 32'h00000000);
   endtask

   task automatic wrc(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
      input logic ee);
      logic [31:0] r;
      logic er;
      m.access(1'b1, i, s, d, r, er);
      chk({31'h0, er}, {31'h0, ee});
   endtask

   task automatic pedge(input logic two, input logic lvl, input logic [31:0] pos);
      @(negedge core_clk);
      actualPosition = pos;
      if (two)
         probeTwoIn = lvl;
      else
         probeOneIn = lvl;
      @(negedge core_clk);
      actualPosition = ~pos;
   endtask

   task automatic t_reset();
      rdc(16'h6085, 8'h00, 32'h0007A120);
      rdc(16'h6098, 8'h00, 32'h00000011);
      rdc(16'h6099, 8'h01, 32'h00002710);
      rdc(16'h6099, 8'h02, 32'h000007D0);
      rdc(16'h609A, 8'h00, 32'h000186A0);
      rdc(16'h60B8, 8'h00, 32'h00000000);
      rdc(16'h60B9, 8'h00, 32'h00000000);
      for (int k = 0; k < 4; k++)
         rdc(16'h60BA + 16'(k), 8'h00, 32'h00000000);
      rdc(16'h60FF, 8'h00, 32'h00000000);
      rdc(16'h6502, 8'h00, 32'h000000A5);
      chk(homingDecel, 32'h000186A0);
      chk({31'h0, reverseDirection}, 32'h00000000);
      $display("test reset values done");
   endtask

   task automatic t_method();
      wrc(16'h6098, 8'h00, 32'h00000010, 1'b1);
      wrc(16'h6098, 8'h00, 32'h00000023, 1'b0);
      rdc(16'h6098, 8'h00, 32'h00000023);
      wrc(16'h6098, 8'h00, 32'h00000024, 1'b1);
      wrc(16'h6098, 8'h00, 32'h000000FF, 1'b1);
      chk({24'h0, homingMethod}, 32'h00000023);
      wrc(16'h6098, 8'h00, 32'h00000011, 1'b0);
      chk({24'h0, homingMethod}, 32'h00000011);
      $display("test homing method done");
   endtask

   task automatic t_motion();
      wrc(16'h6085, 8'h00, 32'h000F4240, 1'b0);
      wrc(16'h6099, 8'h01, 32'h12345678, 1'b0);
      wrc(16'h6099, 8'h02, 32'h00000ABC, 1'b0);
      wrc(16'h6099, 8'h03, 32'h00000001, 1'b1);
      wrc(16'h609A, 8'h00, 32'h00030D40, 1'b0);
      wrc(16'h60FF, 8'h00, 32'hFFFFFC18, 1'b0);
      rdc(16'h6099, 8'h01, 32'h12345678);
      rdc(16'h6099, 8'h02, 32'h00000ABC);
      chk(homingSpeedFast, 32'h12345678);
      chk(homingSpeedSlow, 32'h00000ABC);
      chk(homingAccel, 32'h00030D40);
      chk(homingDecel, 32'h00030D40);
      chk(quickStopDecel, 32'h000F4240);
      chk(targetSpeed, 32'hFFFFFC18);
      chk({31'h0, reverseDirection}, 32'h00000001);
      wrc(16'h60FF, 8'h00, 32'h000003E8, 1'b0);
      chk({31'h0, reverseDirection}, 32'h00000000);
      $display("test motion parameters done");
   endtask

   task automatic t_readonly();
      logic [31:0] r;
      logic er;
      wrc(16'h6502, 8'h00, 32'h00000000, 1'b1);
      wrc(16'h60B9, 8'h00, 32'h00000707, 1'b1);
      wrc(16'h60BA, 8'h00, 32'h00000055, 1'b1);
      wrc(16'h60FD, 8'h00, 32'h00000007, 1'b1);
      rdc(16'h6502, 8'h00, 32'h000000A5);
      rdc(16'h60BA, 8'h00, 32'h00000000);
      m.access(1'b0, 16'h6000, 8'h00, 32'h00000000, r, er);
      chk({31'h0, er}, 32'h00000001);
      $display("test read-only objects done");
   endtask

   task automatic t_inputs();
      @(negedge core_clk);
      {homeSensorIn, cwLimitIn, ccwLimitIn} = 3'b101;
      isolatedInputs = 6'b101001;
      rdc(16'h60FD, 8'h00, 32'h00290005);
      {homeSensorIn, cwLimitIn, ccwLimitIn} = 3'b010;
      isolatedInputs = 6'b010110;
      rdc(16'h60FD, 8'h00, 32'h00160002);
      {homeSensorIn, cwLimitIn, ccwLimitIn} = 3'b000;
      $display("test input monitor done");
   endtask

   // The sensor stays hit when the mode drops, so only the mode gating clears the request.
   task automatic t_qstop();
      for (int k = 0; k < 3; k++)
      begin
         @(negedge core_clk);
         {homingMode, profileVelocityMode, profilePositionMode} = 3'b001 << k;
         {homeSensorIn, cwLimitIn, ccwLimitIn} = 3'b001 << k;
         repeat (3) @(negedge core_clk);
         chk({31'h0, quickStopRequest}, 32'h00000001);
         {homingMode, profileVelocityMode, profilePositionMode} = 3'b000;
         repeat (3) @(negedge core_clk);
         chk({31'h0, quickStopRequest}, 32'h00000000);
         {homeSensorIn, cwLimitIn, ccwLimitIn} = 3'b000;
      end
      $display("test quick stop done");
   endtask

   // A low clock enable must hold the quick-stop request even while a hit stands.
   task automatic t_freeze();
      @(negedge core_clk);
      clkEn = 1'b0;
      homingMode = 1'b1;
      homeSensorIn = 1'b1;
      repeat (3) @(negedge core_clk);
      chk({31'h0, quickStopRequest}, 32'h00000000);
      clkEn = 1'b1;
      repeat (2) @(negedge core_clk);
      chk({31'h0, quickStopRequest}, 32'h00000001);
      {homingMode, homeSensorIn} = 2'b00;
      repeat (2) @(negedge core_clk);
      $display("test clock enable done");
   endtask

   task automatic t_probe();
      wrc(16'h60B8, 8'h00, 32'h00003131, 1'b0);
      rdc(16'h60B9, 8'h00, 32'h00000101);
      pedge(1'b0, 1'b1, 32'hA0000001);
      rdc(16'h60B9, 8'h00, 32'h00000103);
      rdc(16'h60BA, 8'h00, 32'hA0000001);
      pedge(1'b0, 1'b0, 32'hA0000002);
      rdc(16'h60B9, 8'h00, 32'h00000107);
      rdc(16'h60BB, 8'h00, 32'hA0000002);
      pedge(1'b1, 1'b1, 32'hB0000001);
      pedge(1'b1, 1'b0, 32'hB0000002);
      rdc(16'h60B9, 8'h00, 32'h00000707);
      rdc(16'h60BC, 8'h00, 32'hB0000001);
      rdc(16'h60BD, 8'h00, 32'hB0000002);
      wrc(16'h60B8, 8'h00, 32'h00002131, 1'b0);
      rdc(16'h60B9, 8'h00, 32'h00000507);
      pedge(1'b1, 1'b1, 32'hC0000001);
      rdc(16'h60BC, 8'h00, 32'hB0000001);
      rdc(16'h60B9, 8'h00, 32'h00000507);
      wrc(16'h60B8, 8'h00, 32'h00000000, 1'b0);
      rdc(16'h60B9, 8'h00, 32'h00000000);
      pedge(1'b0, 1'b1, 32'hC0000002);
      rdc(16'h60BA, 8'h00, 32'hA0000001);
      $display("test touch probes done");
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      reset = 1'b0;
      t_reset();
      t_method();
      t_motion();
      t_readonly();
      t_inputs();
      t_qstop();
      t_freeze();
      t_probe();
      close_out();
   end

   // The tests need well under a thousand cycles; three thousand leaves ample margin.
   initial
   begin
      #(40 * 3000);
      n_errors++;
      close_out();
   end
endmodule
